// ---- hdl/pcs_pkg.sv ----
package pcs_pkg;
	localparam int CLK_MHZ = 250;
	localparam int HOLDOFF_US = 100;
	localparam int SUSPEND_US = 250;
	localparam int RELOCK_US = 100;
	localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
	localparam int TIMER_W = 17;
	localparam int LOCK_FILTER_CYC = 16;
	localparam int LOCK_CNT_W = 8;
	localparam int WINDOW_PERIODS = 6;
	localparam int COUNT_W = 8;
	localparam logic [7:0] X24_MAX = 8'hA5;
	localparam logic [7:0] X24_MIN = 8'h7D;
	localparam logic [7:0] X12_MAX = 8'h54;
	localparam logic [7:0] X12_MIN = 8'h3D;
	localparam logic [9:0] ADDR_PLL_SETUP = 10'h1C6;
	localparam logic [9:0] ADDR_FALLBACK = 10'h1C7;
	localparam logic [9:0] ADDR_SPI_ERROR = 10'h1D3;
	localparam int PS_FACTOR_BIT = 0;
	localparam int PS_SPREAD_BIT = 1;
	localparam int FB_BACKUP_BIT = 0;
	localparam int FB_RETURN_BIT = 1;
	localparam int FB_DRVDIS_BIT = 2;
	localparam int SE_CLKMISS_BIT = 0;
	localparam logic PS_FACTOR_RST = 1'h1;
	localparam logic PS_SPREAD_RST = 1'h0;
	localparam logic FB_DRVDIS_RST = 1'h0;

	typedef enum logic [2:0] {
		ST_HOLDOFF = 3'h0,
		ST_USE_EXT = 3'h1,
		ST_LOCK_BACKUP = 3'h2,
		ST_USE_BACKUP = 3'h3,
		ST_SWITCH_BACK = 3'h4
	} pcs_state_t;

	function automatic logic pcs_count_bad(input logic [7:0] cnt, input logic f24);
		if (f24) begin
			return (cnt > X24_MAX) || (cnt < X24_MIN);
		end
		return (cnt > X12_MAX) || (cnt < X12_MIN);
	endfunction
endpackage

// ---- hdl/pcs_rst_sync.sv ----
`timescale 1ns/1ps
module pcs_rst_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic power_on_reset_n,
	input wire logic backup_ref_clk,
	output logic mon_rst_n,
	output logic backup_rise
);
	wire arst_n = rst_n & reset_pin_n & power_on_reset_n;
	logic [2:0] bk_sync_reg;
	logic [1:0] rel_reg;

	// Release waits for a second backup reference edge, so the monitor starts in step with it
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			// Reset high so a backup pin already high at release gives no false edge
			bk_sync_reg <= 3'h7;
			rel_reg <= 2'h0;
		end else begin
			bk_sync_reg <= {bk_sync_reg[1:0], backup_ref_clk};
			if (backup_rise) begin
				rel_reg <= {rel_reg[0], 1'b1};
			end
		end
	end

	assign backup_rise = bk_sync_reg[1] & ~bk_sync_reg[2];
	assign mon_rst_n = rel_reg[1];
endmodule // pcs_rst_sync

// ---- hdl/pcs_freq_mon.sv ----
`timescale 1ns/1ps
module pcs_freq_mon #(
	parameter int PERIODS = pcs_pkg::WINDOW_PERIODS,
	parameter int CNT_W = pcs_pkg::COUNT_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic backup_tick,
	input wire logic pll_tick,
	output logic window_done,
	output logic [CNT_W-1:0] window_count
);
	import pcs_pkg::*;
	logic started_reg;
	logic [3:0] per_reg;
	logic [CNT_W-1:0] cnt_reg;
	wire last_per = backup_tick && started_reg && (per_reg == 4'(PERIODS - 1));
	wire cnt_sat = &cnt_reg;

	// Saturating count keeps a runaway clock reading as too fast
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			started_reg <= 1'b0;
			per_reg <= 4'h0;
			cnt_reg <= '0;
			window_done <= 1'b0;
			window_count <= '0;
		end else begin
			window_done <= last_per && enable;
			if (!enable) begin
				started_reg <= 1'b0;
				per_reg <= 4'h0;
				cnt_reg <= '0;
			end else if (backup_tick && !started_reg) begin
				started_reg <= 1'b1;
				cnt_reg <= '0;
			end else if (last_per) begin
				window_count <= cnt_reg;
				per_reg <= 4'h0;
				cnt_reg <= '0;
			end else begin
				if (backup_tick) begin
					per_reg <= per_reg + 4'h1;
				end
				if (pll_tick && !cnt_sat) begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule // pcs_freq_mon

// ---- hdl/pcs_clock_supervisor.sv ----
`timescale 1ns/1ps
module pcs_clock_supervisor #(
	parameter int HOLD_CYC = pcs_pkg::HOLDOFF_CYC,
	parameter int SUSP_CYC = pcs_pkg::SUSPEND_CYC,
	parameter int RELOCK_CYC = pcs_pkg::RELOCK_CYC,
	parameter int LOCK_FILT_CYC = pcs_pkg::LOCK_FILTER_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic power_on_reset_n,
	input wire logic backup_ref_clk,
	input wire logic pll_out_clk,
	input wire logic pll_lock,
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_abort,
	output logic pll_ref_backup_sel,
	output logic pll_factor_24,
	output logic pll_spread_disable,
	output logic sysclk_enable,
	output logic backup_ref_active,
	output logic clock_missing,
	output logic driver_enable,
	output logic core_irq,
	output logic interrupt_out_n
);
	import pcs_pkg::*;

	logic mon_rst_n;
	logic backup_rise;
	logic win_done;
	logic [COUNT_W-1:0] win_count;
	pcs_state_t state_reg;
	pcs_state_t state_next;
	logic [2:0] pll_sync_reg;
	logic [1:0] lock_sync_reg;
	logic [LOCK_CNT_W-1:0] lock_cnt_reg;
	logic lock_filt_reg;
	logic freq_ok_reg;
	logic valid_prev_reg;
	logic seen_fall_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic [TIMER_W-1:0] valid_cnt_reg;
	logic factor_sel_reg;
	logic factor_act_reg;
	logic spread_dis_reg;
	logic drv_dis_reg;
	logic spi_err_reg;

	pcs_rst_sync u_rst_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reset_pin_n(reset_pin_n),
		.power_on_reset_n(power_on_reset_n),
		.backup_ref_clk(backup_ref_clk),
		.mon_rst_n(mon_rst_n),
		.backup_rise(backup_rise)
	);

	wire pll_rise = pll_sync_reg[1] & ~pll_sync_reg[2];
	wire suspend = (state_reg == ST_SWITCH_BACK) && (timer_reg < TIMER_W'(SUSP_CYC));
	wire mon_en = (state_reg != ST_HOLDOFF) && !suspend;

	pcs_freq_mon u_freq_mon (
		.ref_clk(ref_clk),
		.rst_n(mon_rst_n),
		.enable(mon_en),
		.backup_tick(backup_rise),
		.pll_tick(pll_rise),
		.window_done(win_done),
		.window_count(win_count)
	);

	// Register decode; every access is refused while the system clock is missing
	wire acc_ok = !clock_missing;
	wire wr_setup = reg_wr && acc_ok && (reg_addr == ADDR_PLL_SETUP);
	wire wr_fallback = reg_wr && acc_ok && (reg_addr == ADDR_FALLBACK);
	wire rd_spi_err = reg_rd && acc_ok && (reg_addr == ADDR_SPI_ERROR);
	wire acc_abort = (reg_wr || reg_rd) && clock_missing;
	wire return_req = wr_fallback && reg_wdata[FB_RETURN_BIT] && (state_reg == ST_USE_BACKUP);

	wire win_bad = pcs_count_bad(win_count, factor_act_reg);
	wire out_valid = lock_filt_reg && freq_ok_reg;
	wire relock_edge = seen_fall_reg && out_valid && !valid_prev_reg;
	wire relock_time = out_valid && (valid_cnt_reg >= TIMER_W'(RELOCK_CYC - 1));
	wire holdoff_end = timer_reg >= TIMER_W'(HOLD_CYC - 1);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLDOFF: begin
				if (holdoff_end) begin
					state_next = ST_USE_EXT;
				end
			end
			ST_USE_EXT: begin
				if (win_done && win_bad) begin
					state_next = ST_LOCK_BACKUP;
				end
			end
			ST_LOCK_BACKUP: begin
				if (win_done && !win_bad && lock_filt_reg) begin
					state_next = ST_USE_BACKUP;
				end
			end
			ST_USE_BACKUP: begin
				if (return_req) begin
					state_next = ST_SWITCH_BACK;
				end
			end
			ST_SWITCH_BACK: begin
				if (relock_edge || relock_time) begin
					state_next = ST_USE_EXT;
				end else if (win_done && win_bad) begin
					state_next = ST_LOCK_BACKUP;
				end
			end
			default: begin
				state_next = ST_HOLDOFF;
			end
		endcase
	end

	// Indications follow the state directly so no stale flag survives a transition
	assign pll_ref_backup_sel = (state_reg == ST_LOCK_BACKUP) || (state_reg == ST_USE_BACKUP);
	assign backup_ref_active = pll_ref_backup_sel;
	assign clock_missing = (state_reg == ST_LOCK_BACKUP) || (state_reg == ST_SWITCH_BACK);
	assign core_irq = clock_missing;
	assign interrupt_out_n = !clock_missing;
	assign driver_enable = !(drv_dis_reg && clock_missing);
	assign sysclk_enable = lock_filt_reg;
	assign pll_factor_24 = factor_act_reg;
	assign pll_spread_disable = spread_dis_reg;
	assign reg_abort = acc_abort;

	always_ff @(posedge ref_clk or negedge mon_rst_n) begin
		if (!mon_rst_n) begin
			state_reg <= ST_HOLDOFF;
			timer_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				timer_reg <= '0;
			end else if (!(&timer_reg)) begin
				timer_reg <= timer_reg + 1'b1;
			end
		end
	end

	// Pin inputs pass two flops before use; lock is filtered against glitches
	always_ff @(posedge ref_clk or negedge mon_rst_n) begin
		if (!mon_rst_n) begin
			pll_sync_reg <= 3'h0;
			lock_sync_reg <= 2'h0;
			lock_cnt_reg <= '0;
			lock_filt_reg <= 1'b0;
		end else begin
			pll_sync_reg <= {pll_sync_reg[1:0], pll_out_clk};
			lock_sync_reg <= {lock_sync_reg[0], pll_lock};
			if (!lock_sync_reg[1]) begin
				lock_cnt_reg <= '0;
				lock_filt_reg <= 1'b0;
			end else if (lock_cnt_reg >= LOCK_CNT_W'(LOCK_FILT_CYC - 1)) begin
				lock_filt_reg <= 1'b1;
			end else begin
				lock_cnt_reg <= lock_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge mon_rst_n) begin
		if (!mon_rst_n) begin
			freq_ok_reg <= 1'b1;
			valid_prev_reg <= 1'b0;
			seen_fall_reg <= 1'b0;
			valid_cnt_reg <= '0;
			factor_act_reg <= PS_FACTOR_RST;
		end else begin
			valid_prev_reg <= out_valid;
			if (win_done) begin
				freq_ok_reg <= !win_bad;
			end
			if (win_done || !mon_en) begin
				factor_act_reg <= factor_sel_reg;
			end
			if (state_reg != ST_SWITCH_BACK || !out_valid) begin
				valid_cnt_reg <= '0;
			end else if (!(&valid_cnt_reg)) begin
				valid_cnt_reg <= valid_cnt_reg + 1'b1;
			end
			if (state_reg != ST_SWITCH_BACK) begin
				seen_fall_reg <= 1'b0;
			end else if (valid_prev_reg && !out_valid) begin
				seen_fall_reg <= 1'b1;
			end
		end
	end

	// Error flag clears on read, but a new abort in the same cycle wins
	always_ff @(posedge ref_clk or negedge mon_rst_n) begin
		if (!mon_rst_n) begin
			factor_sel_reg <= PS_FACTOR_RST;
			spread_dis_reg <= PS_SPREAD_RST;
			drv_dis_reg <= FB_DRVDIS_RST;
			spi_err_reg <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			if (wr_setup) begin
				factor_sel_reg <= reg_wdata[PS_FACTOR_BIT];
				spread_dis_reg <= reg_wdata[PS_SPREAD_BIT];
			end
			if (wr_fallback) begin
				drv_dis_reg <= reg_wdata[FB_DRVDIS_BIT];
			end
			if (acc_abort) begin
				spi_err_reg <= 1'b1;
			end else if (rd_spi_err) begin
				spi_err_reg <= 1'b0;
			end
			reg_rdata <= 16'h0000;
			if (reg_rd && acc_ok) begin
				case (reg_addr)
					ADDR_PLL_SETUP: begin
						reg_rdata[PS_FACTOR_BIT] <= factor_sel_reg;
						reg_rdata[PS_SPREAD_BIT] <= spread_dis_reg;
					end
					ADDR_FALLBACK: begin
						reg_rdata[FB_BACKUP_BIT] <= backup_ref_active;
						reg_rdata[FB_DRVDIS_BIT] <= drv_dis_reg;
					end
					ADDR_SPI_ERROR: begin
						reg_rdata[SE_CLKMISS_BIT] <= spi_err_reg;
					end
					default: begin
						reg_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!mon_rst_n);

	sequence return_taken_s;
		state_reg == ST_USE_BACKUP && return_req;
	endsequence
	sequence switching_s;
		clock_missing && !backup_ref_active && !mon_en && !pll_ref_backup_sel;
	endsequence

	gate_follows_lock_a: assert property (!lock_sync_reg[1] |=> !sysclk_enable)
		else $error("system clock not gated after lock loss");
	backup_flag_a: assert property ($rose(backup_ref_active) |-> $past(win_done && win_bad))
		else $error("backup flag raised without an invalid window");
	irq_pin_a: assert property ($rose(core_irq)
		|-> !interrupt_out_n && $past((win_done && win_bad) || return_req))
		else $error("interrupt raised without a missing clock");
	drv_off_a: assert property (drv_dis_reg && clock_missing |-> !driver_enable)
		else $error("drivers left on while clock missing");
	holdoff_quiet_a: assert property (state_reg == ST_HOLDOFF |-> !clock_missing && !backup_ref_active && !mon_en)
		else $error("supervision active during hold-off");
	limit_x24_a: assert property (win_done && factor_act_reg
		|-> win_bad == ((win_count > X24_MAX) || (win_count < X24_MIN)))
		else $error("x24 window verdict wrong");
	limit_x12_a: assert property (win_done && !factor_act_reg
		|-> win_bad == ((win_count > X12_MAX) || (win_count < X12_MIN)))
		else $error("x12 window verdict wrong");
	fallback_entry_a: assert property (state_reg == ST_USE_EXT && win_done && win_bad |=> clock_missing && backup_ref_active)
		else $error("invalid clock did not start fallback");
	no_auto_retest_a: assert property (state_reg == ST_USE_BACKUP && !return_req |=> state_reg == ST_USE_BACKUP)
		else $error("left backup state without request");
	switch_back_a: assert property (return_taken_s |=> switching_s ##1 switching_s)
		else $error("return request did not suspend monitor");
	relock_exit_a: assert property (state_reg == ST_SWITCH_BACK && (relock_edge || relock_time)
		|=> state_reg == ST_USE_EXT && !clock_missing)
		else $error("relock did not return to external reference");
	factor_boundary_a: assert property (mon_en && !win_done && $past(mon_en) |=> $stable(factor_act_reg))
		else $error("factor changed inside a window");
	abort_logged_a: assert property (acc_abort |=> spi_err_reg ##1 (spi_err_reg || $past(rd_spi_err)))
		else $error("aborted access not logged");
endmodule // pcs_clock_supervisor

// ---- dv/pcs_mcu_model.sv ----
`timescale 1ns/1ps
module pcs_mcu_model (
	input wire logic ext_ok,
	input wire logic backup_sel,
	input wire logic factor_24,
	output logic backup_ref_clk,
	output logic pll_out_clk,
	output logic pll_lock
);
	real half_ns;
	// Backup oscillator runs free at 1 MHz
	initial begin
		backup_ref_clk = 1'b0;
		forever #500 backup_ref_clk = ~backup_ref_clk;
	end
	// PLL output stands still when no usable reference feeds it
	initial begin
		pll_out_clk = 1'b0;
		forever begin
			half_ns = factor_24 ? 20.833 : 41.667;
			if (ext_ok || backup_sel) begin
				#(half_ns) pll_out_clk = 1'b1;
				#(half_ns) pll_out_clk = 1'b0;
			end else begin
				#4 pll_out_clk = 1'b0;
			end
		end
	end
	assign pll_lock = ext_ok || backup_sel;
endmodule // pcs_mcu_model

// ---- dv/pcs_clock_supervisor_bench.sv ----
`timescale 1ns/1ps
module pcs_clock_supervisor_bench;
	import pcs_pkg::*;
	logic ref_clk, rst_n, ext_ok, backup_ref_clk, pll_out_clk, pll_lock;
	logic reset_pin_n, power_on_reset_n;
	logic [9:0] reg_addr;
	logic reg_wr, reg_rd;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic reg_abort, pll_ref_backup_sel, pll_factor_24, pll_spread_disable, sysclk_enable;
	logic backup_ref_active, clock_missing, driver_enable, core_irq, interrupt_out_n;
	int failures, n_checks;
	logic [31:0] seed;
	pcs_clock_supervisor #(.HOLD_CYC(200), .SUSP_CYC(500), .RELOCK_CYC(300), .LOCK_FILT_CYC(4))
	pcs_clock_supervisor_i (.ref_clk(ref_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
		.power_on_reset_n(power_on_reset_n),
		.backup_ref_clk(backup_ref_clk), .pll_out_clk(pll_out_clk), .pll_lock(pll_lock), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_abort(reg_abort),
		.pll_ref_backup_sel(pll_ref_backup_sel), .pll_factor_24(pll_factor_24),
		.pll_spread_disable(pll_spread_disable), .sysclk_enable(sysclk_enable),
		.backup_ref_active(backup_ref_active), .clock_missing(clock_missing), .driver_enable(driver_enable),
		.core_irq(core_irq), .interrupt_out_n(interrupt_out_n));
	pcs_mcu_model pcs_mcu_model_i (.ext_ok(ext_ok), .backup_sel(pll_ref_backup_sel),
		.factor_24(pll_factor_24), .backup_ref_clk(backup_ref_clk), .pll_out_clk(pll_out_clk),
		.pll_lock(pll_lock));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Only the two documented setup bits read back
	function automatic logic [15:0] exp_setup(input logic [15:0] w);
		return w & 16'h0003;
	endfunction
	function automatic logic pick(input int sel);
		return (sel == 0) ? clock_missing : pll_factor_24;
	endfunction
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_w({15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk_w(e, reg_rdata);
	endtask
	// Bounded wait; a hang ends the run as a mismatch
	task automatic wait_for(input int sel, input logic e, input int lim);
		int n;
		n = 0;
		while (pick(sel) !== e && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		#1;
		if (n >= lim) begin
			chk_b(pick(sel), e);
			complete_run();
		end
	endtask
	initial begin
		#380000;
		failures++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		reset_pin_n = 1'b1;
		power_on_reset_n = 1'b0;
		ext_ok = 1'b1;
		reg_addr = 10'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		failures = 0;
		n_checks = 0;
		seed = 96465;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		power_on_reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk_b(clock_missing, 1'b0);
		chk_b(interrupt_out_n, 1'b1);
		chk_b(pll_ref_backup_sel, 1'b0);
		repeat (600) @(posedge ref_clk);
		rd(ADDR_PLL_SETUP, 16'h0001);
		rd(ADDR_FALLBACK, 16'h0000);
		rd(10'h3FF, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			v = xs();
			wr(ADDR_PLL_SETUP, v);
			chk_b(pll_spread_disable, v[1]);
			rd(ADDR_PLL_SETUP, exp_setup(v));
			wait_for(1, v[0], 1600);
		end
		// Park on x12 first so the x24 change below lines up with a window end
		wr(ADDR_PLL_SETUP, 16'h0000);
		wait_for(1, 1'b0, 1600);
		wr(ADDR_PLL_SETUP, 16'h0001);
		wait_for(1, 1'b1, 1600);
		wr(ADDR_PLL_SETUP, 16'h0000);
		chk_b(pll_factor_24, 1'b1);
		wait_for(1, 1'b0, 1600);
		repeat (3200) @(posedge ref_clk);
		#1;
		chk_b(clock_missing, 1'b0);
		wr(ADDR_PLL_SETUP, 16'h0001);
		wait_for(1, 1'b1, 1600);
		repeat (3200) @(posedge ref_clk);
		#1;
		chk_b(clock_missing, 1'b0);
		$display("factor test done");
		wr(ADDR_FALLBACK, 16'h0004);
		rd(ADDR_FALLBACK, 16'h0004);
		ext_ok <= 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
		chk_b(sysclk_enable, 1'b0);
		wait_for(0, 1'b1, 3300);
		chk_b(backup_ref_active, 1'b1);
		chk_b(pll_ref_backup_sel, 1'b1);
		chk_b(core_irq, 1'b1);
		chk_b(interrupt_out_n, 1'b0);
		chk_b(driver_enable, 1'b0);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ADDR_FALLBACK;
		#1;
		chk_b(reg_abort, 1'b1);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		wait_for(0, 1'b0, 3300);
		chk_b(sysclk_enable, 1'b1);
		chk_b(backup_ref_active, 1'b1);
		chk_b(driver_enable, 1'b1);
		rd(ADDR_SPI_ERROR, 16'h0001);
		rd(ADDR_SPI_ERROR, 16'h0000);
		rd(ADDR_FALLBACK, 16'h0005);
		ext_ok <= 1'b1;
		repeat (3200) @(posedge ref_clk);
		#1;
		chk_b(backup_ref_active, 1'b1);
		$display("fallback test done");
		// Return request is the last word; the bus then stays idle until relock
		wr(ADDR_FALLBACK, 16'h0006);
		chk_b(clock_missing, 1'b1);
		chk_b(backup_ref_active, 1'b0);
		chk_b(pll_ref_backup_sel, 1'b0);
		chk_b(driver_enable, 1'b0);
		repeat (250) @(posedge ref_clk);
		#1;
		chk_b(clock_missing, 1'b1);
		wait_for(0, 1'b0, 800);
		rd(ADDR_FALLBACK, 16'h0004);
		$display("return test done");
		// Pin reset during fallback: flags drop at once, registers stay held until backup edges
		ext_ok <= 1'b0;
		wait_for(0, 1'b1, 3300);
		@(posedge ref_clk);
		reset_pin_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_pin_n <= 1'b1;
		ext_ok <= 1'b1;
		#1;
		chk_b(clock_missing, 1'b0);
		chk_b(backup_ref_active, 1'b0);
		chk_b(interrupt_out_n, 1'b1);
		wr(ADDR_PLL_SETUP, 16'h0002);
		chk_b(pll_spread_disable, 1'b0);
		repeat (800) @(posedge ref_clk);
		rd(ADDR_FALLBACK, 16'h0000);
		rd(ADDR_PLL_SETUP, 16'h0001);
		$display("reset pin test done");
		complete_run();
	end
endmodule // pcs_clock_supervisor_bench
